// ===== spd_engine.sv
// Split descriptor engine: fetch, schedule, and write back transfer descriptors
`timescale 1ns/1ps
`include "spd_regs.svh"
module spd_engine (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [`SPD_MEM_AW-1:0] reg_addr_in,
   input wire logic [`SPD_DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [`SPD_DATA_W-1:0] reg_rdata_out,
   input wire logic uframe_tick_in,
   input wire logic [2:0] uframe_index_in,
   input wire logic [4:0] frame_num_in,
   output logic txn_start_out,
   output spd_pkg::spd_txn_t txn_out,
   input wire spd_pkg::spd_result_t result_in,
   output logic busy_out,
   output logic skip_out,
   output logic retire_out
);

   localparam int NCACHE = 8;

   spd_pkg::spd_state_t st;
   spd_pkg::spd_state_t next_st;
   logic [3:0] step;
   logic [3:0] next_step;
   logic [`SPD_DATA_W-1:0] cache [0:NCACHE-1];
   logic [`SPD_DATA_W-1:0] next_cache [0:NCACHE-1];
   logic [2:0] uf;
   logic [2:0] next_uf;
   logic [4:0] frame;
   logic [4:0] next_frame;
   logic [10:0] count;
   logic [10:0] next_count;
   logic fatal;
   logic next_fatal;
   spd_pkg::spd_txn_t next_txn;
   logic next_txn_start;
   logic next_skip;
   logic next_retire;

   logic [`SPD_MEM_AW-1:0] b_addr;
   logic [`SPD_DATA_W-1:0] b_wdata;
   logic [`SPD_DATA_W-1:0] b_rdata;
   logic b_we;
   logic b_re;

   logic valid_bit;
   logic frame_ok;
   logic sa_hit;
   logic cs_hit;
   logic phase;
   logic phase_new;
   logic split_on;
   logic is_iso;
   logic is_in;
   logic done_new;
   logic [10:0] chunk;
   logic [10:0] len;
   logic [14:0] to_move;
   logic [14:0] remaining;
   logic [11:0] moved;
   logic [11:0] moved_new;
   logic [12:0] moved_sum;
   logic [7:0] cs_left;
   logic [2:0] slot_c;
   logic [1:0] slot_lane;
   logic [7:0] slot_now;

   // Memory word that belongs to each cache slot
   function automatic logic [`SPD_MEM_AW-1:0] word_of(input logic [2:0] idx);
      logic [`SPD_MEM_AW-1:0] w;
      w = `SPD_W_DW0L;
      unique case (idx)
         `SPD_C_DW0L: w = `SPD_W_DW0L;
         `SPD_C_DW1H: w = `SPD_W_DW1H;
         `SPD_C_DW2L: w = `SPD_W_DW2L;
         `SPD_C_DW3H: w = `SPD_W_DW3H;
         `SPD_C_DW4L: w = `SPD_W_DW4L;
         `SPD_C_DW5H: w = `SPD_W_DW5H;
         `SPD_C_DW6L: w = `SPD_W_DW6L;
         `SPD_C_DW7H: w = `SPD_W_DW7H;
      endcase
      return w;
   endfunction : word_of

   function automatic logic token_is_in(input logic [1:0] token);
      return token == `SPD_TOKEN_IN;
   endfunction : token_is_in

   spd_desc_mem #(
      .AW(`SPD_MEM_AW),
      .DW(`SPD_DATA_W)
   ) u_mem (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .a_addr_in(reg_addr_in),
      .a_wdata_in(reg_wdata_in),
      .a_we_in(reg_wr_in),
      .a_re_in(reg_rd_in),
      .a_rdata_out(reg_rdata_out),
      .b_addr_in(b_addr),
      .b_wdata_in(b_wdata),
      .b_we_in(b_we),
      .b_re_in(b_re),
      .b_rdata_out(b_rdata)
   );

   // Field decode from the fetched descriptor
   always_comb
   begin
      valid_bit = cache[`SPD_C_DW0L][`SPD_V_BIT];
      chunk = cache[`SPD_C_DW0L][`SPD_CHUNK_HI:`SPD_CHUNK_LO];
      to_move = cache[`SPD_C_DW0L][`SPD_BTM_HI:`SPD_BTM_LO];
      frame_ok = cache[`SPD_C_DW2L][`SPD_FRAME_HI:`SPD_FRAME_LO] == frame;
      sa_hit = cache[`SPD_C_DW4L][`SPD_MASK_LO + uf];
      cs_hit = cache[`SPD_C_DW5H][`SPD_MASK_LO + uf];
      phase = cache[`SPD_C_DW3H][`SPD_PHASE_BIT];
      split_on = cache[`SPD_C_DW1H][`SPD_SPLIT_BIT];
      is_iso = cache[`SPD_C_DW1H][`SPD_TYPE_HI:`SPD_TYPE_LO] == `SPD_TYPE_ISO;
      is_in = token_is_in(cache[`SPD_C_DW1H][`SPD_TOKEN_HI:`SPD_TOKEN_LO]);
      moved = cache[`SPD_C_DW3H][`SPD_MOVED_HI:`SPD_MOVED_LO];
      moved_sum = {1'h0, moved} + {2'h0, count};
      moved_new = moved_sum[12] ? `SPD_MOVED_MAX : moved_sum[11:0];
      // isochronous count is the packet size
      if (is_iso)
      begin
         remaining = to_move;
      end
      else if (to_move > {3'h0, moved})
      begin
         remaining = to_move - {3'h0, moved};
      end
      else
      begin
         remaining = '0;
      end
      len = (remaining > {4'h0, chunk}) ? chunk : remaining[10:0];
      cs_left = cache[`SPD_C_DW5H][`SPD_MASK_HI:`SPD_MASK_LO] & ~(8'h01 << uf);
      // phase moves to complete only for split IN with pending mask
      if (phase == `SPD_PHASE_START)
      begin
         phase_new = (split_on && is_in
            && cache[`SPD_C_DW5H][`SPD_MASK_HI:`SPD_MASK_LO] != 8'h00)
            ? `SPD_PHASE_COMPLETE : `SPD_PHASE_START;
      end
      else
      begin
         phase_new = (cs_left == 8'h00) ? `SPD_PHASE_START : `SPD_PHASE_COMPLETE;
      end
      done_new = (phase_new == `SPD_PHASE_START) && ({3'h0, moved_new} >= to_move);
      if (uf < `SPD_SLOT_DW6_FIRST)
      begin
         slot_c = `SPD_C_DW5H;
         slot_lane = 2'(uf + `SPD_SLOT_DW5_BASE);
      end
      else if (uf < `SPD_SLOT_DW7)
      begin
         slot_c = `SPD_C_DW6L;
         slot_lane = 2'(uf - `SPD_SLOT_DW6_FIRST);
      end
      else
      begin
         slot_c = `SPD_C_DW7H;
         slot_lane = 2'h0;
      end
      slot_now = cache[slot_c][slot_lane*`SPD_SLOT_W +: `SPD_SLOT_W];
   end

   // Sequencer next state
   always_comb
   begin
      next_st = st;
      next_step = step;
      next_cache = cache;
      next_uf = uf;
      next_frame = frame;
      next_count = count;
      next_fatal = fatal;
      next_txn = txn_out;
      next_txn_start = 1'h0;
      next_skip = 1'h0;
      next_retire = 1'h0;
      b_addr = word_of(step[2:0]);
      b_wdata = cache[step[2:0]];
      b_re = 1'h0;
      b_we = 1'h0;
      unique case (st)
         spd_pkg::ST_IDLE:
         begin
            if (uframe_tick_in)
            begin
               next_uf = uframe_index_in;
               next_frame = frame_num_in;
               next_step = 4'h0;
               next_st = spd_pkg::ST_FETCH;
            end
         end
         spd_pkg::ST_FETCH:
         begin
            b_re = !step[3];
            if (step != 4'h0)
            begin
               next_cache[3'(step - 4'h1)] = b_rdata;
            end
            next_step = step + 4'h1;
            if (step == `SPD_FETCH_N)
            begin
               next_st = spd_pkg::ST_DECIDE;
            end
         end
         spd_pkg::ST_DECIDE:
         begin
            if (!valid_bit)
            begin
               next_skip = 1'h1;
               next_st = spd_pkg::ST_IDLE;
            end
            else if (frame_ok && ((phase == `SPD_PHASE_START && sa_hit)
               || (phase == `SPD_PHASE_COMPLETE && cs_hit && is_in)))
            begin
               next_txn.hub_addr = cache[`SPD_C_DW1H][`SPD_HUB_HI:`SPD_HUB_LO];
               next_txn.hub_port_index = cache[`SPD_C_DW1H][`SPD_PORT_HI:`SPD_PORT_LO];
               next_txn.speed_end_field = cache[`SPD_C_DW1H][`SPD_SE_HI:`SPD_SE_LO];
               next_txn.split = split_on;
               next_txn.split_phase_flag = phase;
               next_txn.transfer_type = cache[`SPD_C_DW1H][`SPD_TYPE_HI:`SPD_TYPE_LO];
               next_txn.token = cache[`SPD_C_DW1H][`SPD_TOKEN_HI:`SPD_TOKEN_LO];
               next_txn.function_addr = cache[`SPD_C_DW1H][`SPD_DEV_HI:`SPD_DEV_LO];
               next_txn.endpoint_num = {cache[`SPD_C_DW1H][`SPD_EP_HI:`SPD_EP_LO],
                  cache[`SPD_C_DW0L][`SPD_EP0_BIT]};
               next_txn.len = len;
               next_txn_start = 1'h1;
               next_st = spd_pkg::ST_WAIT;
            end
            else
            begin
               next_st = spd_pkg::ST_IDLE;
            end
         end
         spd_pkg::ST_WAIT:
         begin
            if (result_in.done)
            begin
               next_count = result_in.count;
               next_fatal = result_in.fatal;
               next_st = spd_pkg::ST_UPDATE;
            end
         end
         spd_pkg::ST_UPDATE:
         begin
            if (fatal)
            begin
               next_cache[`SPD_C_DW0L][`SPD_V_BIT] = 1'h0;
               next_retire = 1'h1;
            end
            else
            begin
               if (sa_hit)
               begin
                  next_cache[slot_c][slot_lane*`SPD_SLOT_W +: `SPD_SLOT_W] =
                     count[`SPD_SLOT_W-1:0];
               end
               next_cache[`SPD_C_DW3H][`SPD_MOVED_HI:`SPD_MOVED_LO] = moved_new;
               next_cache[`SPD_C_DW3H][`SPD_PHASE_BIT] = phase_new;
               if (phase == `SPD_PHASE_COMPLETE)
               begin
                  next_cache[`SPD_C_DW5H][`SPD_MASK_HI:`SPD_MASK_LO] = cs_left;
               end
               if (done_new)
               begin
                  next_cache[`SPD_C_DW0L][`SPD_V_BIT] = 1'h0;
                  next_retire = 1'h1;
               end
            end
            next_step = 4'h0;
            next_st = spd_pkg::ST_WRITE;
         end
         spd_pkg::ST_WRITE:
         begin
            b_we = 1'h1;
            next_step = step + 4'h1;
            if (step[2:0] == `SPD_LAST_IDX)
            begin
               next_st = spd_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         st <= spd_pkg::ST_IDLE;
         step <= 4'h0;
         uf <= 3'h0;
         frame <= 5'h00;
         count <= 11'h000;
         fatal <= 1'h0;
         txn_out <= '0;
         txn_start_out <= 1'h0;
         skip_out <= 1'h0;
         retire_out <= 1'h0;
         for (int i = 0; i < NCACHE; i++)
         begin
            cache[i] <= '0;
         end
      end
      else
      begin
         st <= next_st;
         step <= next_step;
         uf <= next_uf;
         frame <= next_frame;
         count <= next_count;
         fatal <= next_fatal;
         txn_out <= next_txn;
         txn_start_out <= next_txn_start;
         skip_out <= next_skip;
         retire_out <= next_retire;
         for (int i = 0; i < NCACHE; i++)
         begin
            cache[i] <= next_cache[i];
         end
      end
   end

   assign busy_out = (st != spd_pkg::ST_IDLE);

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   property p_chunk_cap;
      txn_start_out |-> txn_out.len <= chunk;
   endproperty
   a_chunk_cap: assert property (p_chunk_cap)
      else $error("transaction length above chunk limit");

   property p_iso_mps;
      txn_start_out && is_iso |->
         txn_out.len == ((to_move > {4'h0, chunk}) ? chunk : to_move[10:0]);
   endproperty
   a_iso_mps: assert property (p_iso_mps)
      else $error("isochronous length not taken from byte count");

   property p_fatal_clear;
      st == spd_pkg::ST_UPDATE && fatal |=> !valid_bit && retire_out;
   endproperty
   a_fatal_clear: assert property (p_fatal_clear)
      else $error("valid not cleared after fatal error");

   property p_fields;
      txn_start_out |-> txn_out.hub_addr == cache[`SPD_C_DW1H][`SPD_HUB_HI:`SPD_HUB_LO]
         && txn_out.function_addr == cache[`SPD_C_DW1H][`SPD_DEV_HI:`SPD_DEV_LO]
         && txn_out.endpoint_num[0] == cache[`SPD_C_DW0L][`SPD_EP0_BIT];
   endproperty
   a_fields: assert property (p_fields)
      else $error("addressing fields do not match descriptor");

   property p_moved;
      st == spd_pkg::ST_UPDATE && !fatal && !moved_sum[12] |=>
         moved == $past(moved) + $past(count);
   endproperty
   a_moved: assert property (p_moved)
      else $error("byte count not accumulated");

   property p_phase;
      txn_start_out |-> txn_out.split_phase_flag == phase;
   endproperty
   a_phase: assert property (p_phase)
      else $error("phase flag not carried to transaction");

   property p_split;
      txn_start_out |-> txn_out.split == split_on && st == spd_pkg::ST_WAIT;
   endproperty
   a_split: assert property (p_split)
      else $error("split flag not carried to transaction");

   property p_cs_in;
      txn_start_out && txn_out.split_phase_flag == `SPD_PHASE_COMPLETE |->
         txn_out.token == `SPD_TOKEN_IN;
   endproperty
   a_cs_in: assert property (p_cs_in)
      else $error("complete split issued for OUT token");

   property p_slot;
      st == spd_pkg::ST_UPDATE && !fatal && sa_hit |=>
         slot_now == $past(count[`SPD_SLOT_W-1:0]);
   endproperty
   a_slot: assert property (p_slot)
      else $error("microframe slot not updated");

   property p_skip;
      st == spd_pkg::ST_DECIDE && !valid_bit |=>
         skip_out && !txn_start_out && st == spd_pkg::ST_IDLE;
   endproperty
   a_skip: assert property (p_skip)
      else $error("inactive descriptor was scheduled");

   property p_fetch_len;
      st == spd_pkg::ST_IDLE && uframe_tick_in |=>
         st == spd_pkg::ST_FETCH [*8] ##1 st == spd_pkg::ST_FETCH ##1 st == spd_pkg::ST_DECIDE;
   endproperty
   a_fetch_len: assert property (p_fetch_len)
      else $error("fetch did not take nine cycles");

   c_start: cover property (txn_start_out && txn_out.split_phase_flag == `SPD_PHASE_START);
   c_complete: cover property (txn_start_out && txn_out.split_phase_flag == `SPD_PHASE_COMPLETE);
   c_retire: cover property (retire_out && !fatal);
   c_skip: cover property (skip_out);

endmodule : spd_engine

// ===== spd_regs.svh
// Descriptor layout, codes and sizes for the split descriptor engine
//
// Contract
// - Per-start-split chunk limit is the 11-bit field at descriptor bits 28:18.
// - For isochronous descriptors the byte count acts as downstream maximum packet size.
// - Hardware clears valid bit 0 when fully executed or on a fatal error.
// - Second word holds hub, port, speed/end, split, type, token, address, endpoint.
// - Hardware reports completed bytes in a 12-bit count covering 4 kbytes.
// - Split flag 0 gives a plain high-speed transaction, 1 a split transaction.
// - Token 00 means OUT and 01 means IN.
// - Matching microframe with start-split bit set stores its byte count in its slot.
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH

// Descriptor memory geometry and fetch length
`define SPD_MEM_AW 4
`define SPD_DATA_W 32
`define SPD_FETCH_N 4'h8
`define SPD_LAST_IDX 3'h7

// Memory words that the engine fetches and writes back
`define SPD_W_DW0L 4'h0
`define SPD_W_DW1H 4'h3
`define SPD_W_DW2L 4'h4
`define SPD_W_DW3H 4'h7
`define SPD_W_DW4L 4'h8
`define SPD_W_DW5H 4'hb
`define SPD_W_DW6L 4'hc
`define SPD_W_DW7H 4'hf

// Local cache slots for those words
`define SPD_C_DW0L 3'h0
`define SPD_C_DW1H 3'h1
`define SPD_C_DW2L 3'h2
`define SPD_C_DW3H 3'h3
`define SPD_C_DW4L 3'h4
`define SPD_C_DW5H 3'h5
`define SPD_C_DW6L 3'h6
`define SPD_C_DW7H 3'h7

// Word 0 fields
`define SPD_V_BIT 0
`define SPD_BTM_HI 17
`define SPD_BTM_LO 3
`define SPD_CHUNK_HI 28
`define SPD_CHUNK_LO 18
`define SPD_EP0_BIT 31

// Upper half of the second descriptor word
`define SPD_HUB_HI 31
`define SPD_HUB_LO 25
`define SPD_PORT_HI 24
`define SPD_PORT_LO 18
`define SPD_SE_HI 17
`define SPD_SE_LO 16
`define SPD_SPLIT_BIT 14
`define SPD_TYPE_HI 13
`define SPD_TYPE_LO 12
`define SPD_TOKEN_HI 11
`define SPD_TOKEN_LO 10
`define SPD_DEV_HI 9
`define SPD_DEV_LO 3
`define SPD_EP_HI 2
`define SPD_EP_LO 0

// Frame select, phase, byte count, masks and result slots
`define SPD_FRAME_HI 7
`define SPD_FRAME_LO 3
`define SPD_PHASE_BIT 27
`define SPD_MOVED_HI 11
`define SPD_MOVED_LO 0
`define SPD_MASK_HI 7
`define SPD_MASK_LO 0
`define SPD_SLOT_W 8
`define SPD_SLOT_DW5_BASE 3'h1
`define SPD_SLOT_DW6_FIRST 3'h3
`define SPD_SLOT_DW7 3'h7

// Codes
`define SPD_TOKEN_OUT 2'h0
`define SPD_TOKEN_IN 2'h1
`define SPD_TYPE_ISO 2'h1
`define SPD_PHASE_START 1'h0
`define SPD_PHASE_COMPLETE 1'h1
`define SPD_MOVED_MAX 12'hfff

`endif

// ===== spd_pkg.sv
// Shared types for the split descriptor engine
package spd_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH,
      ST_DECIDE,
      ST_WAIT,
      ST_UPDATE,
      ST_WRITE
   } spd_state_t;

   typedef struct packed {
      logic [6:0] hub_addr;
      logic [6:0] hub_port_index;
      logic [1:0] speed_end_field;
      logic split;
      logic split_phase_flag;
      logic [1:0] transfer_type;
      logic [1:0] token;
      logic [6:0] function_addr;
      logic [3:0] endpoint_num;
      logic [10:0] len;
   } spd_txn_t;

   typedef struct packed {
      logic done;
      logic fatal;
      logic [10:0] count;
   } spd_result_t;

endpackage : spd_pkg

// ===== spd_desc_mem.sv
// Two-port descriptor memory with registered read data
`timescale 1ns/1ps
module spd_desc_mem #(
   parameter int AW = 4,
   parameter int DW = 32
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [AW-1:0] a_addr_in,
   input wire logic [DW-1:0] a_wdata_in,
   input wire logic a_we_in,
   input wire logic a_re_in,
   output logic [DW-1:0] a_rdata_out,
   input wire logic [AW-1:0] b_addr_in,
   input wire logic [DW-1:0] b_wdata_in,
   input wire logic b_we_in,
   input wire logic b_re_in,
   output logic [DW-1:0] b_rdata_out
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Port A wins when both ports write one word in the same cycle
   always_ff @(posedge clk_in)
   begin
      if (a_we_in)
      begin
         mem[a_addr_in] <= a_wdata_in;
      end
      if (b_we_in && !(a_we_in && (a_addr_in == b_addr_in)))
      begin
         mem[b_addr_in] <= b_wdata_in;
      end
   end

   // Read data stand only in the cycle after a read
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         a_rdata_out <= '0;
         b_rdata_out <= '0;
      end
      else
      begin
         a_rdata_out <= a_re_in ? mem[a_addr_in] : '0;
         b_rdata_out <= b_re_in ? mem[b_addr_in] : '0;
      end
   end

endmodule : spd_desc_mem

// ===== spd_far_end.sv
// Downstream device model that answers split transactions
`timescale 1ns/1ps
module spd_far_end (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic txn_start_in,
   input wire spd_pkg::spd_txn_t txn_in,
   input wire logic [3:0] delay_in,
   input wire logic [1:0] short_in,
   input wire logic fatal_in,
   output spd_pkg::spd_result_t result_out
);
   logic pend;
   logic [3:0] wait_cnt;
   logic [10:0] last;
   logic [10:0] cnt;
   // Short IN packets return fewer bytes than asked
   assign cnt = (txn_in.token == 2'h1 && txn_in.len > short_in) ? txn_in.len - short_in : txn_in.len;
   always_ff @(posedge clk_in)
   begin
      result_out.done <= 1'h0;
      result_out.fatal <= 1'h0;
      // Idle count lines never repeat the last answer
      result_out.count <= ~last;
      if (reset_in)
      begin
         pend <= 1'h0;
         last <= '0;
      end
      else if (txn_start_in)
      begin
         pend <= 1'h1;
         wait_cnt <= delay_in;
      end
      else if (pend && wait_cnt != 4'h0)
         wait_cnt <= wait_cnt - 4'h1;
      else if (pend)
      begin
         pend <= 1'h0;
         result_out.done <= 1'h1;
         result_out.fatal <= fatal_in;
         result_out.count <= cnt;
         last <= cnt;
      end
   end
endmodule : spd_far_end

// ===== tb_split_transfer_descriptor.sv
// Self-checking bench for the split descriptor engine
`timescale 1ns/1ps
module tb_split_transfer_descriptor;
   localparam logic [4:0] FR = 5'h0b;
   logic clk_in = 1'h0;
   logic reset_in = 1'h1;
   logic [3:0] reg_addr_in = '0;
   logic [31:0] reg_wdata_in = '0;
   logic reg_wr_in = 1'h0;
   logic reg_rd_in = 1'h0;
   logic [31:0] reg_rdata_out;
   logic uframe_tick_in = 1'h0;
   logic [2:0] uframe_index_in = '0;
   logic [4:0] frame_num_in = '0;
   logic txn_start_out, busy_out, skip_out, retire_out;
   spd_pkg::spd_txn_t txn_out, last_txn;
   spd_pkg::spd_result_t result_in;
   logic [3:0] dly = '0;
   logic [1:0] shrt = '0;
   logic fat = 1'h0;
   logic [31:0] img [16];
   logic [31:0] b, e, d;
   int seed = 32'h077d96d5;
   int n_fail = 0, checked = 0, n_txn = 0, n_skip = 0, n_ret = 0;
   initial forever #50 clk_in = ~clk_in;
   spd_engine dut (.clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
      .reg_rdata_out, .uframe_tick_in, .uframe_index_in, .frame_num_in, .txn_start_out,
      .txn_out, .result_in, .busy_out, .skip_out, .retire_out);
   spd_far_end far (.clk_in, .reset_in, .txn_start_in(txn_start_out), .txn_in(txn_out),
      .delay_in(dly), .short_in(shrt), .fatal_in(fat), .result_out(result_in));
   always @(posedge clk_in)
   begin
      if (txn_start_out === 1'h1)
      begin
         n_txn++;
         last_txn = txn_out;
      end
      if (skip_out === 1'h1) n_skip++;
      if (retire_out === 1'h1) n_ret++;
   end
   task stop_test;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task chk(input bit ok, input string m);
      checked++;
      if (!ok)
      begin
         n_fail++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1'h1;
      img[a] = v;
      @(posedge clk_in);
      reg_wr_in <= 1'h0;
   endtask : wr
   task rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'h1;
      @(posedge clk_in);
      reg_rd_in <= 1'h0;
      #1 v = reg_rdata_out;
   endtask : rd
   task ld(input logic [1:0] tok, typ, input logic spl, input logic [14:0] btm,
      input logic [10:0] cl, input logic [11:0] mv, input logic [7:0] sa, cs);
      for (int i = 0; i < 16; i++) img[i] = $random(seed);
      img[0][28:3] = {cl, btm};
      img[0][0] = 1'h1;
      img[3][14:10] = {spl, typ, tok};
      img[4][7:3] = FR;
      img[7][27] = 1'h0;
      img[7][11:0] = mv;
      img[8][7:0] = sa;
      img[11][7:0] = cs;
      for (int i = 0; i < 16; i++) wr(4'(i), img[i]);
   endtask : ld
   task go(input logic [2:0] uf, input logic [4:0] fr);
      logic [31:0] w0, w1, w3, w4, w5;
      logic sch, ph;
      logic [14:0] rem;
      logic [10:0] ln, c;
      logic [12:0] s;
      int t, k, r;
      w0 = img[0];
      w1 = img[3];
      w3 = img[7];
      w4 = img[8];
      w5 = img[11];
      ph = w3[27];
      sch = w0[0] && img[4][7:3] == fr && (ph ? w5[uf] && w1[11:10] == 2'h1 : w4[uf]);
      rem = w1[13:12] == 2'h1 ? w0[17:3] : w0[17:3] > w3[11:0] ? w0[17:3] - w3[11:0] : '0;
      ln = rem > w0[28:18] ? w0[28:18] : rem[10:0];
      c = (w1[11:10] == 2'h1 && ln > shrt) ? ln - shrt : ln;
      t = n_txn;
      k = n_skip;
      r = n_ret;
      @(posedge clk_in);
      dly <= 4'($random(seed));
      uframe_tick_in <= 1'h1;
      uframe_index_in <= uf;
      frame_num_in <= fr;
      @(posedge clk_in);
      uframe_tick_in <= 1'h0;
      #1;
      for (int i = 0; i < 80 && busy_out !== 1'h0; i++)
      begin
         @(posedge clk_in);
         #1;
      end
      chk(busy_out === 1'h0, "engine hang");
      repeat (2) @(posedge clk_in);
      if (sch && fat)
         img[0][0] = 1'h0;
      else if (sch)
      begin
         if (w4[uf] && uf < 3) img[11][8*uf+8 +: 8] = c[7:0];
         else if (w4[uf] && uf < 7) img[12][8*(uf-3) +: 8] = c[7:0];
         else if (w4[uf]) img[15][7:0] = c[7:0];
         s = w3[11:0] + c;
         img[7][11:0] = s > 13'hfff ? 12'hfff : s[11:0];
         if (!ph)
            img[7][27] = w1[14] && w1[11:10] == 2'h1 && w5[7:0] != 8'h0;
         else
         begin
            img[11][uf] = 1'h0;
            img[7][27] = img[11][7:0] != 8'h0;
         end
         if (!img[7][27] && img[7][11:0] >= w0[17:3]) img[0][0] = 1'h0;
      end
      chk(n_txn == t + int'(sch), "schedule");
      chk(n_skip == k + int'(!w0[0]), "skip");
      chk(n_ret == r + int'(sch && !img[0][0]), "retire");
      e = {w1[31:25], w1[24:18], w1[17:16], w1[14], ph, w1[13:12], w1[11:10], w1[9:3], w1[2:0]};
      if (sch) chk(last_txn === {e, w0[31], ln}, "txn");
      for (int i = 0; i < 16; i++)
      begin
         rd(4'(i), d);
         chk(d === img[i], "write-back");
      end
   endtask : go
   initial
   begin
      #5000000;
      n_fail++;
      stop_test;
   end
   initial
   begin
      repeat (6) @(posedge clk_in);
      reset_in <= 1'h0;
      @(posedge clk_in);
      #1 chk({busy_out, txn_start_out, skip_out, retire_out} === 4'h0, "reset");
      wr(4'h5, 32'h5a3c_0f96);
      rd(4'h5, d);
      chk(d === 32'h5a3c_0f96, "readback");
      @(posedge clk_in);
      #1 chk(reg_rdata_out === '0, "read data held");
      for (int i = 0; i < 8; i++)
      begin
         b = $random(seed);
         e = $random(seed);
         shrt <= b[27:26];
         ld({1'h0, b[0]}, b[2:1], b[3], 15'(b[13:4]),
            b[13:4] > 10'h0bc ? (b[0] ? 11'h0c0 : 11'h0bc) : 11'(b[13:4]),
            12'(b[25:18]), e[7:0], e[15:8]);
         go(b[30:28], FR);
      end
      shrt <= 2'h0;
      ld(2'h0, 2'h0, 1'h0, 15'h040, 11'h040, 12'h0, 8'hff, 8'h0);
      wr(4'h0, img[0] & 32'hffff_fffe);
      go(3'h2, FR);
      ld(2'h0, 2'h0, 1'h0, 15'h040, 11'h040, 12'h0, 8'hff, 8'h0);
      go(3'h4, FR + 5'h1);
      go(3'h4, FR);
      ld(2'h1, 2'h2, 1'h1, 15'h12c, 11'h0c0, 12'h0, 8'h01, 8'h0c);
      go(3'h0, FR);
      go(3'h1, FR);
      go(3'h2, FR);
      go(3'h3, FR);
      go(3'h3, FR);
      ld(2'h0, 2'h0, 1'h0, 15'h080, 11'h020, 12'h0, 8'h01, 8'h0);
      fat <= 1'h1;
      go(3'h0, FR);
      fat <= 1'h0;
      ld(2'h0, 2'h1, 1'h1, 15'h064, 11'h064, 12'h050, 8'h80, 8'h0);
      go(3'h7, FR);
      ld(2'h0, 2'h0, 1'h0, 15'h7fff, 11'h7ff, 12'hffe, 8'h40, 8'h0);
      go(3'h6, FR);
      shrt <= 2'h3;
      ld(2'h1, 2'h0, 1'h0, 15'h020, 11'h010, 12'h0, 8'h20, 8'h0);
      go(3'h5, FR);
      stop_test;
   end
endmodule : tb_split_transfer_descriptor
